// ==== core/motor_startup_config_regs.v ====
// Motor start-up configuration registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "startup_cfg_map.vh"
// Function
// R1: Threshold codes 0-E map 0.156-3.75 A
// R2: Detection runs repeat field plus one
// R3: Ramp torque current down during handoff when enabled
// R4: Active braking only while enable set
// R5: Reverse drive picks reverse or forward settings
// R6: Second settings register at 86h, reset zero
// R7: Release brake/tristate; advance angle 0-90 degrees
module motor_startup_config_regs (
  input  wire        CLK_SYS,
  input  wire        SRST,
  input  wire [9:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [9:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        REVERSE_DRIVE,
  input  wire        DETECT_START,
  input  wire        HANDOFF_ACTIVE,
  output reg  [11:0] DETECT_THRESHOLD_MA,
  output reg         DETECT_THRESHOLD_VALID,
  output reg         DETECT_BUSY,
  output reg         DETECT_PASS_PULSE,
  output reg         RELEASE_TRISTATE,
  output reg  [6:0]  ADVANCE_ANGLE_DEG,
  output reg         IQ_RAMPDOWN,
  output reg         ACTIVE_BRAKE,
  output reg         USE_REVERSE_SET,
  output reg  [3:0]  OL_ILIMIT_SEL,
  output reg  [3:0]  OL_ACC_A1_SEL,
  output reg  [3:0]  OL_ACC_A2_SEL
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge, used by both registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    input [31:0] wmask;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
      merge = merge & wmask;
    end
  endfunction

  // Regional decode: 0 = settings a, 1 = settings b, 2 = unmapped
  function [1:0] decode;
    input [9:0] addr;
    begin
      if (addr == `SETA_ADDR) begin
        decode = 2'h0;
      end else if (addr == `SETB_ADDR) begin
        decode = 2'h1;
      end else begin
        decode = 2'h2;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [31:0] seta_r;
  reg  [31:0] setb_r;
  reg  [9:0]  awaddr_r;
  reg         aw_held_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_held_r;
  reg         detect_busy_r;
  reg  [1:0]  pass_cnt_r;
  reg         detect_sync1_r;
  reg         detect_sync2_r;
  reg         detect_prev_r;
  wire [11:0] thr_ma;
  wire        thr_ok;
  wire        do_write;
  wire [1:0]  wsel;
  wire [1:0]  rsel;
  wire        detect_rise;

  // Write fires once both address and data are held, response free
  assign do_write = aw_held_r && w_held_r && !S_AXI_BVALID;
  assign wsel     = decode(awaddr_r);
  assign rsel     = decode(S_AXI_ARADDR);

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 10'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      seta_r        <= `SETA_RESET;
      setb_r        <= `SETB_RESET; // R6
    end else begin
      // Ready one cycle per beat, so each handshake captures once
      S_AXI_AWREADY <= !aw_held_r && S_AXI_AWVALID && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_held_r && S_AXI_WVALID && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb_r  <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wsel == 2'h2) ? `RESP_SLVERR : `RESP_OKAY;
        if (wsel == 2'h0) begin
          seta_r <= merge(seta_r, wdata_r, wstrb_r, `SETA_WMASK);
        end
        if (wsel == 2'h1) begin
          setb_r <= merge(setb_r, wdata_r, wstrb_r, 32'hFFFFFFFF); // R6
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  // Reads return the stored words; reserved bit 3 is masked on write
  // so it always reads zero without a separate read path
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= (rsel == 2'h2) ? `RESP_SLVERR : `RESP_OKAY;
        case (rsel)
          2'h0:    S_AXI_RDATA <= seta_r;
          2'h1:    S_AXI_RDATA <= setb_r;
          default: S_AXI_RDATA <= 32'h00000000;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Position detect pass sequencer
  // ----------------------------------------------------------------
  // Start comes from the sequencer pin: synchronise before use
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      detect_sync1_r <= 1'b0;
      detect_sync2_r <= 1'b0;
      detect_prev_r  <= 1'b0;
    end else begin
      detect_sync1_r <= DETECT_START;
      detect_sync2_r <= detect_sync1_r;
      detect_prev_r  <= detect_sync2_r;
    end
  end
  assign detect_rise = detect_sync2_r && !detect_prev_r;

  // One pass pulse per cycle, repeat field plus one passes in all
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      detect_busy_r     <= 1'b0;
      pass_cnt_r        <= 2'h0;
      DETECT_PASS_PULSE <= 1'b0;
    end else begin
      DETECT_PASS_PULSE <= 1'b0;
      if (!detect_busy_r && detect_rise) begin
        detect_busy_r     <= 1'b1;
        pass_cnt_r        <= seta_r[`REP_MSB:`REP_LSB]; // R2
        DETECT_PASS_PULSE <= 1'b1;
      end else if (detect_busy_r) begin
        if (pass_cnt_r == 2'h0) begin
          detect_busy_r <= 1'b0; // R2
        end else begin
          pass_cnt_r        <= pass_cnt_r - 2'h1;
          DETECT_PASS_PULSE <= 1'b1; // R2
        end
      end
    end
  end

  threshold_decode u_thr (
    .CLK_SYS      (CLK_SYS),
    .SRST         (SRST),
    .code         (seta_r[`THR_MSB:`THR_LSB]),
    .milliamps_r  (thr_ma),
    .code_valid_r (thr_ok)
  );

  // ----------------------------------------------------------------
  // Control outputs to the motor sequencer
  // ----------------------------------------------------------------
  // Reverse-drive select is applied only while reverse drive runs
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      DETECT_THRESHOLD_MA    <= 12'h000;
      DETECT_THRESHOLD_VALID <= 1'b0;
      DETECT_BUSY            <= 1'b0;
      RELEASE_TRISTATE       <= 1'b0;
      ADVANCE_ANGLE_DEG      <= 7'h00;
      IQ_RAMPDOWN            <= 1'b0;
      ACTIVE_BRAKE           <= 1'b0;
      USE_REVERSE_SET        <= 1'b0;
      OL_ILIMIT_SEL          <= 4'h0;
      OL_ACC_A1_SEL          <= 4'h0;
      OL_ACC_A2_SEL          <= 4'h0;
    end else begin
      DETECT_THRESHOLD_MA    <= thr_ma; // R1
      DETECT_THRESHOLD_VALID <= thr_ok; // R1
      DETECT_BUSY            <= detect_busy_r;
      RELEASE_TRISTATE       <= seta_r[`RLS_BIT]; // R7
      ADVANCE_ANGLE_DEG      <= {5'h00, seta_r[`ADV_MSB:`ADV_LSB]} * 7'h1E; // R7
      IQ_RAMPDOWN            <= seta_r[`RAMP_BIT] && HANDOFF_ACTIVE; // R3
      ACTIVE_BRAKE           <= seta_r[`BRAKE_BIT]; // R4
      USE_REVERSE_SET        <= REVERSE_DRIVE && seta_r[`REVSEL_BIT]; // R5
      OL_ILIMIT_SEL          <= setb_r[`OLI_MSB:`OLI_LSB];
      OL_ACC_A1_SEL          <= setb_r[`A1_MSB:`A1_LSB];
      OL_ACC_A2_SEL          <= setb_r[`A2_MSB:`A2_LSB];
    end
  end
endmodule // motor_startup_config_regs
`default_nettype wire

// ==== core/startup_cfg_map.vh ====
// Register offsets, field positions, reset values and decode constants
`ifndef STARTUP_CFG_MAP_VH
`define STARTUP_CFG_MAP_VH
// Byte offsets (register index times four, since 86h is not word aligned)
`define SETA_INDEX        8'h85
`define SETB_INDEX        8'h86
`define SETA_ADDR         10'h214
`define SETB_ADDR         10'h218
// Reset values
`define SETA_RESET        32'h00000000
`define SETB_RESET        32'h00000000
// Writable bits of settings a (bit 3 is reserved, reads zero)
`define SETA_WMASK        32'hFFFFFFF7
// Field positions in settings a
`define THR_MSB           13
`define THR_LSB           9
`define RLS_BIT           8
`define ADV_MSB           7
`define ADV_LSB           6
`define REP_MSB           5
`define REP_LSB           4
`define RAMP_BIT          2
`define BRAKE_BIT         1
`define REVSEL_BIT        0
// Field positions in settings b
`define OLI_MSB           30
`define OLI_LSB           27
`define A1_MSB            26
`define A1_LSB            23
`define A2_MSB            22
`define A2_LSB            19
// Highest threshold code that is applicable
`define THR_MAX_CODE      5'h0E
// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ==== core/threshold_decode.v ====
// Position detect current threshold decoder, in milliamps
`timescale 1ns/1ps
`default_nettype none
`include "startup_cfg_map.vh"
module threshold_decode (
  input  wire        CLK_SYS,
  input  wire        SRST,
  input  wire [4:0]  code,
  output reg  [11:0] milliamps_r,
  output reg         code_valid_r
);
  // ----------------------------------------------------------------
  // Table lookup, registered so the top sees flop outputs
  // ----------------------------------------------------------------
  reg [11:0] ma_nxt;
  always @* begin
    case (code)
      5'h00:   ma_nxt = 12'h09C; // 156
      5'h01:   ma_nxt = 12'h138; // 312
      5'h02:   ma_nxt = 12'h1D4; // 468
      5'h03:   ma_nxt = 12'h271; // 625
      5'h04:   ma_nxt = 12'h30D; // 781
      5'h05:   ma_nxt = 12'h3A9; // 937
      5'h06:   ma_nxt = 12'h4E2; // 1250
      5'h07:   ma_nxt = 12'h61A; // 1562
      5'h08:   ma_nxt = 12'h753; // 1875
      5'h09:   ma_nxt = 12'h8F3; // 2291
      5'h0A:   ma_nxt = 12'h9C4; // 2500
      5'h0B:   ma_nxt = 12'hB64; // 2916
      5'h0C:   ma_nxt = 12'hC35; // 3125
      5'h0D:   ma_nxt = 12'hD05; // 3333
      5'h0E:   ma_nxt = 12'hEA6; // 3750
      default: ma_nxt = 12'h000; // Not applicable codes
    endcase
  end

  // Unusable codes flagged rather than clamped, so the sequencer sees it on DETECT_THRESHOLD_VALID
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      milliamps_r  <= 12'h09C;
      code_valid_r <= 1'b1;
    end else begin
      milliamps_r  <= ma_nxt; // R1
      code_valid_r <= (code <= `THR_MAX_CODE); // R1
    end
  end
endmodule // threshold_decode
`default_nettype wire

// ==== verification/motor_startup_config_regs_props.sv ====
// Checker for the motor start-up configuration register block
`timescale 1ns/1ps
`default_nettype none
module startup_cfg_checker (
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic        S_AXI_BVALID,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        REVERSE_DRIVE,
  input wire logic        HANDOFF_ACTIVE,
  input wire logic [11:0] DETECT_THRESHOLD_MA,
  input wire logic        DETECT_THRESHOLD_VALID,
  input wire logic        DETECT_BUSY,
  input wire logic        DETECT_PASS_PULSE,
  input wire logic [6:0]  ADVANCE_ANGLE_DEG,
  input wire logic        IQ_RAMPDOWN,
  input wire logic        ACTIVE_BRAKE,
  input wire logic        USE_REVERSE_SET,
  input wire logic [3:0]  OL_ILIMIT_SEL
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // -------------------------------------------------------------
  // Decode, sequencing and field outputs
  // -------------------------------------------------------------
  property p_thr;
    DETECT_THRESHOLD_VALID ? (DETECT_THRESHOLD_MA inside {[12'h09C:12'hEA6]})
                           : (DETECT_THRESHOLD_MA == 12'h000);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold out of range");
  property p_busy; DETECT_PASS_PULSE |=> DETECT_BUSY; endproperty
  a_busy: assert property (p_busy) else $error("pass without busy");
  property p_rep; DETECT_PASS_PULSE [*4] |=> !DETECT_PASS_PULSE; endproperty
  a_rep: assert property (p_rep) else $error("more than four passes");
  property p_ramp; IQ_RAMPDOWN && !$past(SRST) |-> $past(HANDOFF_ACTIVE); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp outside handoff");
  // Brake may only move after a completed write
  property p_brake; $changed(ACTIVE_BRAKE) && !$past(SRST) |-> $past(S_AXI_BVALID); endproperty
  a_brake: assert property (p_brake) else $error("brake changed without write");
  property p_rev; USE_REVERSE_SET |-> $past(REVERSE_DRIVE); endproperty
  a_rev: assert property (p_rev) else $error("reverse set outside reverse drive");
  property p_ilim;
    $changed(OL_ILIMIT_SEL) && !$past(SRST) |-> $past(S_AXI_BVALID && S_AXI_BRESP == 2'h0);
  endproperty
  a_ilim: assert property (p_ilim) else $error("limit changed without good write");
  property p_angle; ADVANCE_ANGLE_DEG inside {7'h00, 7'h1E, 7'h3C, 7'h5A}; endproperty
  a_angle: assert property (p_angle) else $error("illegal advance angle");
endmodule // startup_cfg_checker

bind motor_startup_config_regs startup_cfg_checker u_startup_cfg_checker (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BRESP(S_AXI_BRESP),
  .REVERSE_DRIVE(REVERSE_DRIVE), .HANDOFF_ACTIVE(HANDOFF_ACTIVE),
  .DETECT_THRESHOLD_MA(DETECT_THRESHOLD_MA), .DETECT_THRESHOLD_VALID(DETECT_THRESHOLD_VALID),
  .DETECT_BUSY(DETECT_BUSY), .DETECT_PASS_PULSE(DETECT_PASS_PULSE),
  .ADVANCE_ANGLE_DEG(ADVANCE_ANGLE_DEG), .IQ_RAMPDOWN(IQ_RAMPDOWN), .ACTIVE_BRAKE(ACTIVE_BRAKE),
  .USE_REVERSE_SET(USE_REVERSE_SET), .OL_ILIMIT_SEL(OL_ILIMIT_SEL));
`default_nettype wire

// ==== verification/test_motor_startup_config_regs.sv ====
// Self-checking bench for the motor start-up configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "startup_cfg_map.vh"
module test_motor_startup_config_regs;
  logic        clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic        arv = 1'b0, rrdy = 1'b0, rev = 1'b0, start = 1'b0, hand = 1'b0;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, wd, d, ma, mb;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  r;
  wire         awrdy, wrdy, bvalid, arrdy, rvalid, thr_ok, busy, pass, tri_r, ramp, brake, use_rev;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [11:0] thr_ma;
  wire  [6:0]  angle;
  wire  [3:0]  ilim, a1, a2;
  integer      seed = 32'hC166, fail_count = 0, num_checks = 0, k;
  int          thr_tab [15] = '{156, 312, 468, 625, 781, 937, 1250, 1562, 1875, 2291, 2500,
                                2916, 3125, 3333, 3750};

  motor_startup_config_regs u_motor_startup_config_regs (
    .CLK_SYS(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(brdy),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rrdy), .REVERSE_DRIVE(rev),
    .DETECT_START(start), .HANDOFF_ACTIVE(hand), .DETECT_THRESHOLD_MA(thr_ma),
    .DETECT_THRESHOLD_VALID(thr_ok), .DETECT_BUSY(busy), .DETECT_PASS_PULSE(pass),
    .RELEASE_TRISTATE(tri_r), .ADVANCE_ANGLE_DEG(angle), .IQ_RAMPDOWN(ramp),
    .ACTIVE_BRAKE(brake), .USE_REVERSE_SET(use_rev), .OL_ILIMIT_SEL(ilim),
    .OL_ACC_A1_SEL(a1), .OL_ACC_A2_SEL(a2));

  // ---------------------------------------------------------------
  // Clock, reporting and bus tasks
  // ---------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Model side of a byte-lane merge
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  // Extra edge at the end keeps back-to-back calls from double-driving
  task automatic wr(input logic [9:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rs);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (n < 40) begin
      @(posedge clk);
      n++;
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        brdy <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) begin
      fail_count++;
      end_sim;
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    while (n < 40) begin
      @(posedge clk);
      n++;
      if (arrdy) arv <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rrdy <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) begin
      fail_count++;
      end_sim;
    end
    @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(`SETA_ADDR, d, r);
    chk(d, `SETA_RESET);
    rd(`SETB_ADDR, d, r);
    chk(d, `SETB_RESET);
    rd(10'h010, d, r);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h00000000);
    wr(10'h010, 32'hFFFFFFFF, 4'hF, r);
    chk(r, `RESP_SLVERR);
    $display("test reset and unmapped done");
    ma = 32'h0;
    // Every threshold code, written through one byte lane only
    for (int c = 0; c < 32; c++) begin
      ma = mrg(ma, {18'h0, c[4:0], 9'h0}, 4'h2);
      wr(`SETA_ADDR, ma, 4'h2, r);
      repeat (3) @(posedge clk);
      chk(thr_ma, c < 15 ? thr_tab[c] : 0);
      chk(thr_ok, c < 15);
    end
    $display("test threshold done");
    for (int i = 0; i < 4; i++) begin
      rev <= i[0];
      hand <= ~i[1];
      wd = $random(seed);
      wd[7:4] = {i[1:0], 2'(3 - i)};
      if (i[0]) wd[2:0] = 3'h7;
      wr(`SETA_ADDR, wd, 4'hF, r);
      ma = wd & `SETA_WMASK;
      rd(`SETA_ADDR, d, r);
      chk(r, `RESP_OKAY);
      chk(d, ma);
      chk(tri_r, ma[8]);
      chk(angle, 30 * i);
      chk(ramp, ma[2] & hand);
      chk(brake, ma[1]);
      chk(use_rev, ma[0] & rev);
      // Count passes inside a window well past the longest run
      start <= 1'b1;
      k = 0;
      repeat (30) begin
        @(posedge clk);
        if (pass === 1'b1) k++;
      end
      start <= 1'b0;
      chk(k, 4 - i);
      chk(busy, 1'b0);
    end
    $display("test fields and detection done");
    wd = $random(seed);
    wr(`SETB_ADDR, wd, 4'hF, r);
    chk(r, `RESP_OKAY);
    mb = mrg(wd, ~wd, 4'h5);
    wr(`SETB_ADDR, ~wd, 4'h5, r);
    rd(`SETB_ADDR, d, r);
    chk(d, mb);
    chk({ilim, a1, a2}, {mb[30:27], mb[26:23], mb[22:19]});
    $display("test second register done");
    end_sim;
  end
endmodule // test_motor_startup_config_regs
`default_nettype wire
